// ==== pre_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the peer exchange
`ifndef PRE_DEFS_SVH
`define PRE_DEFS_SVH

// ==========================================================================
// Register offsets
`define PRE_OFF_PKT_A      16'h0810
`define PRE_OFF_PKT_B      16'h0811
`define PRE_OFF_COL_A      16'h0812
`define PRE_OFF_COL_B      16'h0813
`define PRE_OFF_ACTIVE     16'h0ce7
`define PRE_OFF_INTERVAL   16'h1f4b
`define PRE_OFF_NODE       16'h1f4c
`define PRE_OFF_TX_START   16'h1f4d
`define PRE_OFF_NODE_COUNT 16'h1f5a
`define PRE_OFF_TX_COUNT   16'h1f5b
`define PRE_OFF_TX_DEST    16'h1f5c
`define PRE_OFF_FEATURE    16'h1f5e

// ==========================================================================
// Fields and reset values
// Enable is the sixth bit counting the least significant as bit one (value 32)
`define PRE_PEER_EN_BIT    5
`define PRE_CFG_RESET      16'h0000
`define PRE_TX_MAX         16'h0080
`define PRE_ACT_NODES      16
`define PRE_AGE_LIMIT      2'h3

// ==========================================================================
// Timing
`define PRE_CLK_NS         50
`define PRE_MS_NS          1000000
`define PRE_MS_CYCLES      (`PRE_MS_NS / `PRE_CLK_NS)

`endif

// ==== pre_pkg.sv ====
// Types shared by the peer register exchange
`default_nettype none

package pre_pkg;

    typedef enum logic [2:0] {
        PRE_TX_IDLE,
        PRE_TX_SRC,
        PRE_TX_DST,
        PRE_TX_CNT,
        PRE_TX_RDW,
        PRE_TX_DATA
    } pre_tx_st_t;

    typedef enum logic [1:0] {
        PRE_RX_IDLE,
        PRE_RX_DST,
        PRE_RX_CNT,
        PRE_RX_DATA
    } pre_rx_st_t;

    typedef struct packed {
        logic [15:0]      interval;
        logic [15:0]      node;
        logic [15:0]      tx_start;
        logic [15:0]      node_count;
        logic [15:0]      tx_count;
        logic [15:0]      tx_dest;
        logic [15:0]      feature;
        logic [15:0]      pkt_a;
        logic [15:0]      pkt_b;
        logic [15:0]      col_a;
        logic [15:0]      col_b;
        logic [15:0]      active;
        logic [15:0][1:0] age;
        logic [15:0]      ms_cnt;
        logic [15:0]      phase_ms;
        logic             slot_done;
        logic             tx_pend;
        pre_tx_st_t       tx_st;
        logic [15:0]      tx_len;
        logic [15:0]      tx_idx;
        logic             tx_valid;
        logic [15:0]      tx_data;
        logic             tx_first;
        logic             tx_last;
        logic             mem_rd_en;
        logic [15:0]      mem_rd_addr;
        logic             hold;
        pre_rx_st_t       rx_st;
        logic [15:0]      rx_dest;
        logic [15:0]      rx_cnt;
        logic [15:0]      rx_idx;
        logic             rx_keep;
        logic             mem_wr_en;
        logic [15:0]      mem_wr_addr;
        logic [15:0]      mem_wr_data;
        logic [15:0]      rdata;
    } pre_state_t;

endpackage : pre_pkg

`default_nettype wire

// ==== pre_exchange.sv ====
// Peer register exchange engine: scheduler, frame builder, frame receiver, registers
`include "pre_defs.svh"
`default_nettype none

// Behaviour
// - Peer node count register sets how many transmitting slots share each interval.
// - Own node number comes from its register, unrelated to any drop number.
// - Transmitted block starts at the local index in the transmit-start register.
// - Transmit count 1..128 registers; any value, need not match other peers.
// - Frame carries destination index; received blocks are stored from that index.
// - Broadcast repeats every update interval, counted in milliseconds.
// - Interval runs from own broadcast to own next broadcast.
// - Each node transmits only inside its own time slot.
// - One multicast frame per broadcast updates all peers together.
// - Exchange runs only while feature config bit 6 is set.
// - With bit 6 clear, received peer frames are discarded.
// - Node number zero with exchange enabled means receive only, never transmit.
// - Read-only bitmap bit x shows peer x active; cleared when it vanishes.
// - Only node numbers one to sixteen have an activity bit.
// - A vanished peer only clears its bit; own timing is unaffected.
// - No acknowledgement is ever sent for received frames.
// - Peer traffic takes priority over all other outgoing traffic.
// - Two readable collision counters.
// - Two readable packet counters for throughput checks.
module pre_exchange #(
    parameter int unsigned MS_CYCLES = `PRE_MS_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             tx_valid,
    output logic      [15:0] tx_data,
    output logic             tx_first,
    output logic             tx_last,
    input  wire logic        tx_ready,
    input  wire logic        rx_valid,
    input  wire logic [15:0] rx_data,
    input  wire logic        rx_first,
    input  wire logic        rx_last,
    output logic             mem_rd_en,
    output logic      [15:0] mem_rd_addr,
    input  wire logic [15:0] mem_rd_data,
    output logic             mem_wr_en,
    output logic      [15:0] mem_wr_addr,
    output logic      [15:0] mem_wr_data,
    output logic             other_tx_hold,
    input  wire logic        mac_tx_frame,
    input  wire logic        mac_rx_frame,
    input  wire logic        mac_collision,
    input  wire logic        mac_excess_coll
);

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    pre_pkg::pre_state_t s_reg;
    pre_pkg::pre_state_t s_next;

    logic        peer_en;
    logic        tx_ok;
    logic        tx_accept;
    logic        slot_reached;
    logic [31:0] slot_lhs;
    logic [31:0] slot_rhs;
    logic [15:0] len_eff;

    // ======================================================================
    // Derived terms
    assign peer_en   = s_reg.feature[`PRE_PEER_EN_BIT];
    assign tx_accept = s_reg.tx_valid & tx_ready;
    // Listeners (node zero) and unconfigured schedules never get a slot
    assign tx_ok     = peer_en && (s_reg.node != 16'h0) && (s_reg.tx_count != 16'h0)
                       && (s_reg.interval != 16'h0) && (s_reg.node_count != 16'h0);
    // Offset = interval * (node-1) / count, compared by cross product to avoid a divider
    assign slot_lhs  = s_reg.phase_ms * s_reg.node_count;
    assign slot_rhs  = s_reg.interval * (s_reg.node - 16'h1);
    assign slot_reached = (slot_lhs >= slot_rhs);
    assign len_eff   = (s_reg.tx_count > `PRE_TX_MAX) ? `PRE_TX_MAX : s_reg.tx_count;

    // ======================================================================
    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.mem_rd_en = 1'b0;
        s_next.mem_wr_en = 1'b0;
        s_next.rdata     = 16'h0;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `PRE_OFF_INTERVAL:   s_next.interval   = reg_wdata;
                `PRE_OFF_NODE:       s_next.node       = reg_wdata;
                `PRE_OFF_TX_START:   s_next.tx_start   = reg_wdata;
                `PRE_OFF_NODE_COUNT: s_next.node_count = reg_wdata;
                `PRE_OFF_TX_COUNT:   s_next.tx_count   = reg_wdata;
                `PRE_OFF_TX_DEST:    s_next.tx_dest    = reg_wdata;
                `PRE_OFF_FEATURE:    s_next.feature    = reg_wdata;
                default: ;
            endcase
        end

        // Register reads; unmapped addresses return zero
        if (reg_rd) begin
            unique case (reg_addr)
                `PRE_OFF_PKT_A:      s_next.rdata = s_reg.pkt_a;
                `PRE_OFF_PKT_B:      s_next.rdata = s_reg.pkt_b;
                `PRE_OFF_COL_A:      s_next.rdata = s_reg.col_a;
                `PRE_OFF_COL_B:      s_next.rdata = s_reg.col_b;
                `PRE_OFF_ACTIVE:     s_next.rdata = s_reg.active;
                `PRE_OFF_INTERVAL:   s_next.rdata = s_reg.interval;
                `PRE_OFF_NODE:       s_next.rdata = s_reg.node;
                `PRE_OFF_TX_START:   s_next.rdata = s_reg.tx_start;
                `PRE_OFF_NODE_COUNT: s_next.rdata = s_reg.node_count;
                `PRE_OFF_TX_COUNT:   s_next.rdata = s_reg.tx_count;
                `PRE_OFF_TX_DEST:    s_next.rdata = s_reg.tx_dest;
                `PRE_OFF_FEATURE:    s_next.rdata = s_reg.feature;
                default:             s_next.rdata = 16'h0;
            endcase
        end

        // Ethernet statistics, free running and wrapping
        if (mac_tx_frame)    s_next.pkt_a = s_reg.pkt_a + 16'h1;
        if (mac_rx_frame)    s_next.pkt_b = s_reg.pkt_b + 16'h1;
        if (mac_collision)   s_next.col_a = s_reg.col_a + 16'h1;
        if (mac_excess_coll) s_next.col_b = s_reg.col_b + 16'h1;

        // Millisecond timebase and own interval phase
        if (!peer_en) begin
            s_next.ms_cnt    = 16'h0;
            s_next.phase_ms  = 16'h0;
            s_next.slot_done = 1'b0;
            s_next.tx_pend   = 1'b0;
            s_next.active    = 16'h0;
            s_next.age       = '0;
        end else if (s_reg.ms_cnt >= MS_LAST) begin
            s_next.ms_cnt = 16'h0;
            // Phase depends only on own interval, so other peers cannot shift it
            if (!s_reg.slot_done && tx_ok && slot_reached) begin
                s_next.tx_pend   = 1'b1;
                s_next.slot_done = 1'b1;
            end
            if ((s_reg.phase_ms + 16'h1) >= s_reg.interval) begin
                s_next.phase_ms  = 16'h0;
                s_next.slot_done = 1'b0;
                // Peers silent for three intervals drop out of the bitmap
                for (int i = 0; i < `PRE_ACT_NODES; i++) begin
                    if (s_reg.age[i] != `PRE_AGE_LIMIT) begin
                        s_next.age[i] = s_reg.age[i] + 2'h1;
                    end
                    if (s_reg.age[i] + 2'h1 == `PRE_AGE_LIMIT) begin
                        s_next.active[i] = 1'b0;
                    end
                end
            end else begin
                s_next.phase_ms = s_reg.phase_ms + 16'h1;
            end
        end else begin
            s_next.ms_cnt = s_reg.ms_cnt + 16'h1;
        end

        // Frame builder: source, destination, count, then data words
        unique case (s_reg.tx_st)
            pre_pkg::PRE_TX_IDLE: begin
                if (s_reg.tx_pend && tx_ok) begin
                    s_next.tx_pend  = 1'b0;
                    s_next.tx_len   = len_eff;
                    s_next.tx_idx   = 16'h0;
                    s_next.tx_valid = 1'b1;
                    s_next.tx_first = 1'b1;
                    s_next.tx_data  = s_reg.node;
                    s_next.tx_st    = pre_pkg::PRE_TX_SRC;
                end
            end
            pre_pkg::PRE_TX_SRC: begin
                if (tx_accept) begin
                    s_next.tx_first = 1'b0;
                    s_next.tx_data  = s_reg.tx_dest;
                    s_next.tx_st    = pre_pkg::PRE_TX_DST;
                end
            end
            pre_pkg::PRE_TX_DST: begin
                if (tx_accept) begin
                    s_next.tx_data = s_reg.tx_len;
                    s_next.tx_st   = pre_pkg::PRE_TX_CNT;
                end
            end
            pre_pkg::PRE_TX_CNT: begin
                if (tx_accept) begin
                    s_next.tx_valid    = 1'b0;
                    s_next.mem_rd_en   = 1'b1;
                    s_next.mem_rd_addr = s_reg.tx_start;
                    s_next.tx_st       = pre_pkg::PRE_TX_RDW;
                end
            end
            pre_pkg::PRE_TX_RDW: begin
                s_next.tx_valid = 1'b1;
                s_next.tx_data  = mem_rd_data;
                s_next.tx_last  = ((s_reg.tx_idx + 16'h1) == s_reg.tx_len);
                s_next.tx_st    = pre_pkg::PRE_TX_DATA;
            end
            pre_pkg::PRE_TX_DATA: begin
                if (tx_accept) begin
                    s_next.tx_valid = 1'b0;
                    s_next.tx_last  = 1'b0;
                    if (s_reg.tx_last) begin
                        s_next.tx_st = pre_pkg::PRE_TX_IDLE;
                    end else begin
                        s_next.tx_idx      = s_reg.tx_idx + 16'h1;
                        s_next.mem_rd_en   = 1'b1;
                        s_next.mem_rd_addr = s_reg.tx_start + s_reg.tx_idx + 16'h1;
                        s_next.tx_st       = pre_pkg::PRE_TX_RDW;
                    end
                end
            end
            default: s_next.tx_st = pre_pkg::PRE_TX_IDLE;
        endcase
        // Other traffic waits while a peer frame is due or on the wire
        s_next.hold = s_next.tx_pend || (s_next.tx_st != pre_pkg::PRE_TX_IDLE);

        // Frame receiver; a first word always restarts parsing. Nothing is sent back.
        if (rx_valid) begin
            if (rx_first) begin
                s_next.rx_keep = peer_en && (rx_data != 16'h0) && (rx_data != s_reg.node);
                if (peer_en && (rx_data != 16'h0) && (rx_data <= 16'(`PRE_ACT_NODES))
                    && (rx_data != s_reg.node)) begin
                    s_next.active[rx_data[3:0] - 4'h1] = 1'b1;
                    s_next.age[rx_data[3:0] - 4'h1]    = 2'h0;
                end
                s_next.rx_st = pre_pkg::PRE_RX_DST;
            end else begin
                unique case (s_reg.rx_st)
                    pre_pkg::PRE_RX_DST: begin
                        s_next.rx_dest = rx_data;
                        s_next.rx_st   = pre_pkg::PRE_RX_CNT;
                    end
                    pre_pkg::PRE_RX_CNT: begin
                        s_next.rx_cnt = (rx_data > `PRE_TX_MAX) ? `PRE_TX_MAX : rx_data;
                        s_next.rx_idx = 16'h0;
                        s_next.rx_st  = pre_pkg::PRE_RX_DATA;
                    end
                    pre_pkg::PRE_RX_DATA: begin
                        if (s_reg.rx_keep && peer_en && (s_reg.rx_idx < s_reg.rx_cnt)) begin
                            s_next.mem_wr_en   = 1'b1;
                            s_next.mem_wr_addr = s_reg.rx_dest + s_reg.rx_idx;
                            s_next.mem_wr_data = rx_data;
                        end
                        s_next.rx_idx = s_reg.rx_idx + 16'h1;
                    end
                    pre_pkg::PRE_RX_IDLE: ;
                endcase
            end
            if (rx_last) begin
                s_next.rx_st = pre_pkg::PRE_RX_IDLE;
            end
        end
    end

    // ======================================================================
    // State register; configuration powers up cleared, so the exchange starts disabled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg          <= '0;
            s_reg.feature  <= `PRE_CFG_RESET;
            s_reg.interval <= `PRE_CFG_RESET;
            s_reg.tx_st    <= pre_pkg::PRE_TX_IDLE;
            s_reg.rx_st    <= pre_pkg::PRE_RX_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================================
    // Outputs
    assign reg_rdata     = s_reg.rdata;
    assign tx_valid      = s_reg.tx_valid;
    assign tx_data       = s_reg.tx_data;
    assign tx_first      = s_reg.tx_first;
    assign tx_last       = s_reg.tx_last;
    assign mem_rd_en     = s_reg.mem_rd_en;
    assign mem_rd_addr   = s_reg.mem_rd_addr;
    assign mem_wr_en     = s_reg.mem_wr_en;
    assign mem_wr_addr   = s_reg.mem_wr_addr;
    assign mem_wr_data   = s_reg.mem_wr_data;
    assign other_tx_hold = s_reg.hold;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence frame_open_s;
        tx_valid && tx_first && tx_ready;
    endsequence

    sequence dest_word_s;
        tx_valid && !tx_first && (tx_data == $past(s_reg.tx_dest));
    endsequence

    tx_enable_a: assert property (tx_valid && tx_first |-> peer_en)
        else $error("frame started while exchange disabled");
    listen_only_a: assert property (tx_valid && tx_first |-> s_reg.node != 16'h0)
        else $error("frame started by receive-only node");
    tx_dest_a: assert property (frame_open_s |=> dest_word_s)
        else $error("second frame word is not the destination index");
    tx_len_a: assert property (tx_valid && tx_last |->
                               s_reg.tx_idx + 16'h1 == s_reg.tx_len
                               && s_reg.tx_len <= `PRE_TX_MAX && s_reg.tx_len != 16'h0)
        else $error("frame length outside one to 128");
    rd_addr_a: assert property (mem_rd_en |-> mem_rd_addr == s_reg.tx_start + s_reg.tx_idx)
        else $error("local read outside transmit block");
    rx_discard_a: assert property (!peer_en |=> !mem_wr_en)
        else $error("peer data stored while exchange disabled");
    active_clear_a: assert property (!peer_en |=> other_tx_hold == 1'b0 && s_reg.active == 16'h0)
        else $error("bitmap or hold survived disable");
    tx_hold_a: assert property (tx_valid |-> other_tx_hold)
        else $error("peer frame sent without priority hold");
    slot_time_a: assert property ($rose(s_reg.tx_pend) |-> $past(slot_reached && tx_ok))
        else $error("broadcast requested outside own slot");
    read_pulse_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside the read answer cycle");

    sequence rx_data_word_s;
        rx_valid && !rx_first && s_reg.rx_st == pre_pkg::PRE_RX_DATA;
    endsequence

    sequence len_word_s;
        tx_valid && !tx_first && !tx_last && tx_data == s_reg.tx_len;
    endsequence

    cnt_word_a: assert property (tx_accept && s_reg.tx_st == pre_pkg::PRE_TX_DST
                                 |=> len_word_s)
        else $error("third frame word is not the count");

    rx_store_a: assert property (rx_data_word_s ##0 (s_reg.rx_keep && peer_en
                                 && s_reg.rx_idx < s_reg.rx_cnt) |=> mem_wr_en
                                 && mem_wr_addr == $past(s_reg.rx_dest + s_reg.rx_idx))
        else $error("kept word not stored at its index");

    rx_skip_a: assert property (rx_data_word_s ##0 !s_reg.rx_keep |=> !mem_wr_en)
        else $error("discarded frame wrote local registers");

    rx_drop_a: assert property (rx_valid && rx_first && !peer_en |=> !s_reg.rx_keep)
        else $error("frame kept while exchange disabled");

    bitmap_set_a: assert property (rx_valid && rx_first && peer_en
                                   && rx_data != s_reg.node && rx_data inside {[16'h1:16'h10]}
                                   |=> s_reg.active[$past(rx_data[3:0]) - 4'h1])
        else $error("heard peer not marked active");

    bitmap_range_a: assert property (rx_valid && rx_first && rx_data > 16'h10
                                     |=> (s_reg.active & ~$past(s_reg.active)) == 16'h0)
        else $error("activity bit set above node sixteen");

    no_echo_a: assert property (rx_valid && !s_reg.tx_pend
                                && s_reg.tx_st == pre_pkg::PRE_TX_IDLE |=> !tx_valid)
        else $error("reception started a transmission");

    coll_count_a: assert property (mac_collision
                                   |=> s_reg.col_a == $past(s_reg.col_a) + 16'h1)
        else $error("collision not counted");

    pkt_count_a: assert property (mac_rx_frame
                                  |=> s_reg.pkt_b == $past(s_reg.pkt_b) + 16'h1)
        else $error("received packet not counted");

endmodule : pre_exchange

`default_nettype wire

// ==== pre_far_model.sv ====
// Far-side model: MAC transmit sink with stalls and local register space
`default_nettype none

module pre_far_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        mem_rd_en,
    input  wire logic [15:0] mem_rd_addr,
    output logic      [15:0] mem_rd_data,
    output logic             tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  lfsr_reg;
    logic [15:0] churn_reg;

    // ==========================================================================
    // Sink and memory
    // Uneven stalls make the sender hold each word for varying spans
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lfsr_reg    <= 4'h1;
            tx_ready    <= 1'b0;
            churn_reg   <= 16'h0000;
        end else begin
            lfsr_reg    <= {lfsr_reg[2:0], lfsr_reg[3] ^ lfsr_reg[2]};
            tx_ready    <= lfsr_reg[0] | lfsr_reg[1];
            churn_reg   <= ~churn_reg;
        end
    end

    // The sender takes read data in the strobe's own cycle; outside a read the lines
    // churn, so a stale word is never trusted
    assign mem_rd_data = mem_rd_en ? (mem_rd_addr ^ 16'hc3c3) : churn_reg;
endmodule : pre_far_model

`default_nettype wire

// ==== tb_pre_exchange.sv ====
// Self-checking bench of the peer register exchange
`include "pre_defs.svh"
`default_nettype none

module tb_pre_exchange;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS  = 10;
    localparam int IVL = 4;
    // Two transmitters only, 2 ms per node
    localparam logic [15:0] CA [7] = '{`PRE_OFF_INTERVAL, `PRE_OFF_NODE, `PRE_OFF_TX_START,
        `PRE_OFF_NODE_COUNT, `PRE_OFF_TX_COUNT, `PRE_OFF_TX_DEST, `PRE_OFF_FEATURE};
    localparam logic [15:0] CV [7] = '{16'h0004, 16'h0002, 16'h0100, 16'h0002, 16'h0003,
        16'h0040, 16'h0000};
    logic        core_clk, rst, reg_wr, reg_rd, rx_valid, rx_first, rx_last, fv_d, rd_pend;
    logic        tx_valid, tx_first, tx_last, tx_ready, mem_rd_en, mem_wr_en, other_tx_hold;
    logic [3:0]  mac_ev;
    logic [15:0] reg_addr, reg_wdata, rx_data, reg_rdata, tx_data;
    logic [15:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
    logic [15:0] rd_q[$], tx_q[$], wr_q[$];
    int          n_errors, compares, seed, frames, cyc, t_first, cnt;

    pre_exchange #(.MS_CYCLES(MS)) pre_exchange_i (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_first(tx_first),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_first(rx_first), .rx_last(rx_last), .mem_rd_en(mem_rd_en),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .other_tx_hold(other_tx_hold),
        .mac_tx_frame(mac_ev[0]), .mac_rx_frame(mac_ev[1]), .mac_collision(mac_ev[2]),
        .mac_excess_coll(mac_ev[3]));
    pre_far_model pre_far_model_i (.core_clk(core_clk), .rst(rst), .mem_rd_en(mem_rd_en),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .tx_ready(tx_ready));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================================
    // Bus and link drivers
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
    endtask : rd

    task automatic send_rx(input logic [15:0] src, input logic [15:0] dst, input int n,
                           input bit store);
        logic [15:0] d;
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_first <= 1'b1;
        rx_data  <= src;
        @(posedge core_clk);
        rx_first <= 1'b0;
        rx_data  <= dst;
        @(posedge core_clk);
        rx_data  <= 16'(n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            d = 16'($random(seed));
            rx_data <= d;
            rx_last <= (i == n - 1);
            if (store) begin
                wr_q.push_back(dst + 16'(i));
                wr_q.push_back(d);
            end
        end
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        rx_data  <= ~d;
    endtask : send_rx

    // ==========================================================================
    // Output watcher
    always @(posedge core_clk) begin
        rd_pend <= reg_rd;
        cyc++;
    end

    always @(negedge core_clk) begin
        if (rd_pend) begin
            check(reg_rdata, rd_q.size() ? rd_q.pop_front() : 16'hxxxx);
        end
        if (mem_wr_en) begin
            check(mem_wr_addr, wr_q.size() ? wr_q.pop_front() : 16'hxxxx);
            check(mem_wr_data, wr_q.size() ? wr_q.pop_front() : 16'hxxxx);
        end
        if (tx_valid) begin
            check({15'h0000, other_tx_hold}, 16'h0001);
        end
        if (tx_valid && tx_first && !fv_d) begin
            if (frames > 0) begin
                check(16'(cyc - t_first), 16'(IVL * MS));
            end
            t_first = cyc;
        end
        fv_d = tx_valid && tx_first;
        if (tx_valid && tx_ready) begin
            check(tx_data, tx_q.size() ? tx_q.pop_front() : 16'hxxxx);
            if (tx_last) begin
                frames++;
            end
        end
    end

    // ==========================================================================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end

    initial begin
        seed      = 40;
        rst      <= 1'b1;
        {reg_wr, reg_rd, rx_valid, rx_first, rx_last, mac_ev} <= '0;
        reg_addr  <= 16'h0000;
        reg_wdata <= 16'h0000;
        rx_data   <= 16'h0000;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        wr(`PRE_OFF_ACTIVE, 16'hffff);
        wr(`PRE_OFF_PKT_A, 16'hffff);
        rd(16'h0001, 16'h0000);
        for (int i = 0; i < 5; i++) rd(16'h0810 + 16'(i), 16'h0000);
        rd(`PRE_OFF_ACTIVE, 16'h0000);
        for (int i = 0; i < 7; i++) rd(CA[i], 16'h0000);
        for (int i = 0; i < 7; i++) wr(CA[i], CV[i]);
        for (int i = 0; i < 7; i++) rd(CA[i], CV[i]);
        for (int f = 0; f < 2; f++) begin
            tx_q.push_back(16'h0002);
            tx_q.push_back(16'h0040);
            tx_q.push_back(16'h0003);
            for (int i = 0; i < 3; i++) tx_q.push_back((16'h0100 + 16'(i)) ^ 16'hc3c3);
        end
        wr(`PRE_OFF_FEATURE, 16'h0020);
        for (int i = 0; i < 400 && frames < 2; i++) @(posedge core_clk);
        wr(`PRE_OFF_NODE, 16'h0000);
        send_rx(16'h0003, 16'h0020, 2, 1'b1);
        rd(`PRE_OFF_ACTIVE, 16'h0004);
        send_rx(16'h0011, 16'h0030, 1, 1'b1);
        send_rx(16'h0000, 16'h0030, 1, 1'b0);
        rd(`PRE_OFF_ACTIVE, 16'h0004);
        repeat (6 * IVL * MS) @(posedge core_clk);
        rd(`PRE_OFF_ACTIVE, 16'h0000);
        send_rx(16'h0005, 16'h0050, 1, 1'b1);
        rd(`PRE_OFF_ACTIVE, 16'h0010);
        wr(`PRE_OFF_FEATURE, 16'h0000);
        rd(`PRE_OFF_ACTIVE, 16'h0000);
        send_rx(16'h0005, 16'h0050, 2, 1'b0);
        wr(`PRE_OFF_NODE, 16'h0002);
        repeat (3 * IVL * MS) @(posedge core_clk);
        for (int k = 0; k < 4; k++) begin
            cnt = ({$random(seed)} % 4) + 1;
            for (int p = 0; p < cnt; p++) begin
                @(posedge core_clk);
                mac_ev <= 4'h1 << k;
                @(posedge core_clk);
                mac_ev <= 4'h0;
            end
            rd(16'h0810 + 16'(k), 16'(cnt));
        end
        repeat (4) @(posedge core_clk);
        check(16'(frames), 16'h0002);
        check(16'(rd_q.size() + tx_q.size() + wr_q.size()), 16'h0000);
        wrap_up();
    end
endmodule : tb_pre_exchange

`default_nettype wire
